// *** ppms_pkg.sv ***
// Purpose: constants and types for the protector power-mode sequencer
// Assumes: 200 MHz clock, 5 ns period
package ppms_pkg;
    localparam int CLK_MHZ = 200;
    localparam int HOLDOFF_US = 5000;
    localparam int HOLDOFF_CYC = HOLDOFF_US * CLK_MHZ;
    localparam int OV_REC_CYC = 2000000;
    localparam int OC_REC_CYC = 4000000;
    localparam int FLT_DLY_CYC = 200000;
    localparam int TEST_DLY_CYC = 2000;
    localparam int TEST_OC_REC_CYC = 4000;
    localparam int TEST_DWELL_CYC = 400000;
    localparam int CTR_SAMPLE_CYC = 20000;
    localparam int CTR_FULL = 100;
    localparam int CTR_HI_PCT = 70;
    localparam int CTR_LO_PCT = 30;
    localparam int TMR_W = 32;

    typedef enum logic [1:0] {
        PPMS_OFF = 2'b00,
        PPMS_HOLD = 2'b01,
        PPMS_RUN = 2'b10
    } ppms_state_t;
endpackage

// *** ppms_deglitch.sv ***
// Purpose: up/down counter filter for one override input
// Assumes: sample_en_i is a one-cycle enable
// Notes: output held disabled while clear_i is high
`timescale 1ns/1ps
`default_nettype none
module ppms_deglitch
    import ppms_pkg::*;
#(
    parameter int FULL = CTR_FULL
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic clear_i,
    input wire logic sample_en_i,
    input wire logic level_i,
    // Result
    output logic enabled_o,
    output logic settled_o
);
    localparam logic [7:0] HI = 8'((FULL * CTR_HI_PCT) / 100);
    localparam logic [7:0] LO = 8'((FULL * CTR_LO_PCT) / 100);
    localparam logic [7:0] TOP = 8'(FULL);
    logic [7:0] count;
    logic [7:0] next_count;
    logic next_enabled;
    logic next_settled;

    always_comb begin
        next_count = count;
        next_enabled = enabled_o;
        next_settled = settled_o;
        if (clear_i) begin
            next_count = 8'h00;
            next_enabled = 1'b0;
            next_settled = 1'b0;
        end else if (sample_en_i) begin
            if (level_i && count != TOP) next_count = count + 8'h01;
            else if (!level_i && count != 8'h00) next_count = count - 8'h01;
            if (next_count > HI) next_enabled = 1'b1;
            else if (next_count < LO) next_enabled = 1'b0;
            if (next_count > HI || next_count < LO) next_settled = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= 8'h00;
            enabled_o <= 1'b0;
            settled_o <= 1'b0;
        end else begin
            count <= next_count;
            enabled_o <= next_enabled;
            settled_o <= next_settled;
        end
    end

    ctr_band_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (count > HI) |-> enabled_o) else $error("counter high but disabled");
endmodule
`default_nettype wire

// *** ppms_sequencer.sv ***
// Purpose: power-mode, fault gating and fast test mode sequencing
// Assumes: comparator inputs synchronous and already qualified as levels
// Notes: counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module ppms_sequencer
    import ppms_pkg::*;
#(
    parameter int HOLDOFF = HOLDOFF_CYC,
    parameter int OV_REC = OV_REC_CYC,
    parameter int OC_REC = OC_REC_CYC,
    parameter int FLT_DLY = FLT_DLY_CYC,
    parameter int TEST_DLY = TEST_DLY_CYC,
    parameter int TEST_OC_REC = TEST_OC_REC_CYC,
    parameter int TEST_DWELL = TEST_DWELL_CYC,
    parameter int CTR_SAMPLE = CTR_SAMPLE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Supply comparators
    input wire logic supply_above_por_i,
    input wire logic supply_above_cutoff_i,
    input wire logic supply_above_test_entry_i,
    input wire logic supply_at_top_cell_i,
    // Cell and current faults, raw
    input wire logic cell_high_raw_i,
    input wire logic cell_below_release_i,
    input wire logic chg_fault_raw_i,
    input wire logic dsg_fault_raw_i,
    input wire logic current_fault_raw_i,
    // Override inputs
    input wire logic charge_override_input_i,
    input wire logic discharge_override_input_i,
    // Outputs
    output logic charge_fet_drive_o,
    output logic discharge_fet_drive_o,
    output logic state_comparator_en_o,
    output logic fault_detect_en_o,
    output logic fast_test_mode_o,
    output logic fault_mode_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ppms_state_t state, next_state;
    logic [TMR_W-1:0] hold_tmr, next_hold_tmr;
    logic [TMR_W-1:0] ovr_tmr, next_ovr_tmr;
    logic [TMR_W-1:0] dwell_tmr, next_dwell_tmr;
    logic [TMR_W-1:0] samp_tmr, next_samp_tmr;
    logic [TMR_W-1:0] cflt_tmr, next_cflt_tmr;
    logic [TMR_W-1:0] dflt_tmr, next_dflt_tmr;
    logic [TMR_W-1:0] oc_tmr, next_oc_tmr;
    logic [TMR_W-1:0] ovd_tmr, next_ovd_tmr;
    logic ov_flag, next_ov_flag;
    logic cflt, next_cflt, dflt, next_dflt, ocflt, next_ocflt;
    logic test, next_test;
    logic next_chg, next_dsg, next_comp, next_fmode;
    logic sample_en, chg_ok, dsg_ok, chg_set, dsg_set, dg_clear;

    // Saturating down-counter step, shared by every timer but the sample timer
    function automatic logic [TMR_W-1:0] dec(input logic [TMR_W-1:0] v);
        dec = (v == '0) ? '0 : v - 1'b1;
    endfunction

    // Fault detect delay: TEST_DLY cycles in test mode, FLT_DLY otherwise
    function automatic logic [TMR_W-1:0] fdly(input logic t);
        fdly = t ? TMR_W'(TEST_DLY) : TMR_W'(FLT_DLY);
    endfunction

    // ------------------------------------------------------------
    // Override deglitch
    // ------------------------------------------------------------
    assign sample_en = (samp_tmr == '0);
    assign dg_clear = (state == PPMS_OFF);

    ppms_deglitch u_dg_chg (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(dg_clear),
        .sample_en_i(sample_en),
        .level_i(charge_override_input_i),
        .enabled_o(chg_ok),
        .settled_o(chg_set)
    );

    ppms_deglitch u_dg_dsg (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(dg_clear),
        .sample_en_i(sample_en),
        .level_i(discharge_override_input_i),
        .enabled_o(dsg_ok),
        .settled_o(dsg_set)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_hold_tmr = dec(hold_tmr);
        next_ovr_tmr = ovr_tmr;
        next_dwell_tmr = dwell_tmr;
        next_samp_tmr = sample_en ? TMR_W'(CTR_SAMPLE - 1) : samp_tmr - 1'b1;
        next_cflt_tmr = cflt_tmr;
        next_dflt_tmr = dflt_tmr;
        next_oc_tmr = dec(oc_tmr);
        next_ovd_tmr = fdly(test);
        next_ov_flag = ov_flag;
        next_cflt = cflt;
        next_dflt = dflt;
        next_ocflt = ocflt;
        next_test = test;
        case (state)
            PPMS_OFF: begin
                next_ov_flag = 1'b1;
                next_cflt = 1'b0;
                next_dflt = 1'b0;
                next_ocflt = 1'b0;
                next_test = 1'b0;
                next_hold_tmr = TMR_W'(HOLDOFF);
                next_ovr_tmr = TMR_W'(OV_REC);
                if (supply_above_por_i) next_state = PPMS_HOLD;
            end
            PPMS_HOLD: begin
                // Cell-high recovery runs while a longer deglitch still masks
                if (hold_tmr == '0) begin
                    if (!cell_below_release_i) next_ovr_tmr = TMR_W'(OV_REC);
                    else next_ovr_tmr = dec(ovr_tmr);
                    if (cell_below_release_i && ovr_tmr == '0) next_ov_flag = 1'b0;
                end
                // Deglitch masks hold-off: both must finish
                if (hold_tmr == '0 && chg_set && dsg_set) next_state = PPMS_RUN;
            end
            PPMS_RUN: begin
                // Cell-high recovery timer starts after hold-off
                if (ov_flag) begin
                    if (!cell_below_release_i) begin
                        next_ovr_tmr = test ? TMR_W'(TEST_DLY) : TMR_W'(OV_REC);
                    end else begin
                        next_ovr_tmr = dec(ovr_tmr);
                        if (ovr_tmr == '0) next_ov_flag = 1'b0;
                    end
                end else if (cell_high_raw_i) begin
                    // Own qualify timer, the charge-fault timer runs on independently of it
                    next_ovd_tmr = dec(ovd_tmr);
                    if (ovd_tmr == '0) begin
                        next_ov_flag = 1'b1;
                        next_ovr_tmr = test ? TMR_W'(TEST_DLY) : TMR_W'(OV_REC);
                    end
                end
                // Charge-side and discharge-side faults with qualify delay
                next_cflt_tmr = chg_fault_raw_i ? dec(cflt_tmr) : fdly(test);
                if (chg_fault_raw_i && cflt_tmr == '0) next_cflt = 1'b1;
                else if (!chg_fault_raw_i) next_cflt = 1'b0;
                next_dflt_tmr = dsg_fault_raw_i ? dec(dflt_tmr) : fdly(test);
                if (dsg_fault_raw_i && dflt_tmr == '0) next_dflt = 1'b1;
                else if (!dsg_fault_raw_i) next_dflt = 1'b0;
                // Current fault latches, recovery timed
                if (current_fault_raw_i) begin
                    next_ocflt = 1'b1;
                    next_oc_tmr = test ? TMR_W'(TEST_OC_REC) : TMR_W'(OC_REC);
                end else if (oc_tmr == '0) begin
                    next_ocflt = 1'b0;
                end
                // Test mode entry and exit by supply dwell
                if (!test && supply_above_test_entry_i) begin
                    next_dwell_tmr = dec(dwell_tmr);
                    if (dwell_tmr == '0) next_test = 1'b1;
                end else if (test && supply_at_top_cell_i) begin
                    next_dwell_tmr = dec(dwell_tmr);
                    if (dwell_tmr == '0) next_test = 1'b0;
                end else begin
                    next_dwell_tmr = TMR_W'(TEST_DWELL);
                end
                if (next_test != test) next_dwell_tmr = TMR_W'(TEST_DWELL);
            end
            default: next_state = PPMS_OFF;
        endcase
        if (!supply_above_cutoff_i) next_state = PPMS_OFF;
    end

    // ------------------------------------------------------------
    // Driver gating
    // ------------------------------------------------------------
    always_comb begin
        next_chg = 1'b0;
        next_dsg = 1'b0;
        if (next_state == PPMS_RUN && state == PPMS_RUN) begin
            next_chg = supply_above_cutoff_i && chg_ok && !next_ov_flag
                && !next_cflt && !next_ocflt;
            next_dsg = dsg_ok && !next_dflt && !next_ocflt;
        end
        next_comp = next_chg ^ next_dsg;
        next_fmode = (next_state == PPMS_RUN) && (next_ov_flag || next_cflt
            || next_dflt || next_ocflt);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= PPMS_OFF;
            hold_tmr <= '0;
            ovr_tmr <= '0;
            dwell_tmr <= '0;
            samp_tmr <= '0;
            cflt_tmr <= '0;
            dflt_tmr <= '0;
            oc_tmr <= '0;
            ovd_tmr <= '0;
            ov_flag <= 1'b1;
            cflt <= 1'b0;
            dflt <= 1'b0;
            ocflt <= 1'b0;
            test <= 1'b0;
            charge_fet_drive_o <= 1'b0;
            discharge_fet_drive_o <= 1'b0;
            state_comparator_en_o <= 1'b0;
            fault_detect_en_o <= 1'b0;
            fault_mode_o <= 1'b0;
        end else begin
            state <= next_state;
            hold_tmr <= next_hold_tmr;
            ovr_tmr <= next_ovr_tmr;
            dwell_tmr <= next_dwell_tmr;
            samp_tmr <= next_samp_tmr;
            cflt_tmr <= next_cflt_tmr;
            dflt_tmr <= next_dflt_tmr;
            oc_tmr <= next_oc_tmr;
            ovd_tmr <= next_ovd_tmr;
            ov_flag <= next_ov_flag;
            cflt <= next_cflt;
            dflt <= next_dflt;
            ocflt <= next_ocflt;
            test <= next_test;
            charge_fet_drive_o <= next_chg;
            discharge_fet_drive_o <= next_dsg;
            state_comparator_en_o <= next_comp;
            fault_detect_en_o <= (next_state != PPMS_OFF);
            fault_mode_o <= next_fmode;
        end
    end

    assign fast_test_mode_o = test;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_wake;
        state == PPMS_OFF ##1 state == PPMS_HOLD;
    endsequence

    hold_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_wake |-> !charge_fet_drive_o && !discharge_fet_drive_o)
        else $error("driver on during hold-off");
    hold_state_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == PPMS_HOLD) |=> !charge_fet_drive_o && !discharge_fet_drive_o)
        else $error("driver on before deglitch done");
    cutoff_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !supply_above_cutoff_i |=> state == PPMS_OFF && !charge_fet_drive_o)
        else $error("no shutdown below cutoff");
    wake_por_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == PPMS_OFF && !supply_above_por_i) |=> state == PPMS_OFF)
        else $error("woke without power-on level");
    wake_go_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == PPMS_OFF && supply_above_por_i && supply_above_cutoff_i)
        |=> state == PPMS_HOLD)
        else $error("no wake at power-on level");
    comp_xor_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_comparator_en_o == (charge_fet_drive_o ^ discharge_fet_drive_o))
        else $error("comparator enable mismatch");
    ov_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ov_flag |=> !charge_fet_drive_o || !ov_flag)
        else $error("charge on during cell-high fault");
    fault_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(dflt) |-> !discharge_fet_drive_o)
        else $error("discharge on with fault");
    oc_rec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (test && current_fault_raw_i && state == PPMS_RUN && supply_above_cutoff_i)
        |=> oc_tmr == TMR_W'(TEST_OC_REC))
        else $error("test recovery not shortened");
endmodule
`default_nettype wire

// *** ppms_partner.sv ***
// Purpose: pack-side model: supply, top cell and worst cell into comparator levels
// Assumes: bench drives millivolt values off the sampling edge
// Notes: thresholds are plain defaults, not real part figures
`timescale 1ns/1ps
`default_nettype none
module ppms_partner #(
    parameter int POR_MV = 6000,
    parameter int CUT_MV = 4000,
    parameter int ENTRY_MV = 1500,
    parameter int BAND_MV = 50,
    parameter int OV_MV = 4200,
    parameter int REL_MV = 4100
) (
    // Pack voltages
    input wire logic [15:0] supply_mv_i,
    input wire logic [15:0] top_cell_mv_i,
    input wire logic [15:0] cell_max_mv_i,
    // Comparator levels
    output logic por_o,
    output logic cutoff_o,
    output logic entry_o,
    output logic top_o,
    output logic cell_high_o,
    output logic below_rel_o
);
    // Single device only, no stacked neighbour is modelled
    assign por_o = int'(supply_mv_i) >= POR_MV;
    assign cutoff_o = int'(supply_mv_i) >= CUT_MV;
    assign entry_o = int'(supply_mv_i) >= int'(top_cell_mv_i) + ENTRY_MV;
    // Band, since a real tester cannot hit the top cell exactly
    assign top_o = (int'(supply_mv_i) <= int'(top_cell_mv_i) + BAND_MV)
        && (int'(supply_mv_i) + BAND_MV >= int'(top_cell_mv_i));
    assign cell_high_o = int'(cell_max_mv_i) > OV_MV;
    assign below_rel_o = int'(cell_max_mv_i) < REL_MV;
endmodule
`default_nettype wire

// *** ppms_sequencer_bench.sv ***
// Purpose: self-checking bench for the power-mode sequencer
// Assumes: shortened counts, override sampled every cycle
// Notes: windows are bounds, since exact latencies are the design's own
`timescale 1ns/1ps
`default_nettype none
module ppms_sequencer_bench;
    localparam int HOLD = 20;
    localparam int OVR = 20;
    localparam int TD = 1;
    localparam int TOC = 2;
    localparam int DW = 10;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic chg_flt = 1'b0, dsg_flt = 1'b0, cur_flt = 1'b0, ovr_c = 1'b1, ovr_d = 1'b1;
    logic [15:0] sup = 16'h0000, top = 16'h3E80, cmax = 16'h0E74;
    logic por, cut, ent, attop, chigh, brel;
    logic charge_fet_drive, discharge_fet_drive, cmp, fden, fast_test_mode, fmode;
    int bad_count = 0, total_checks = 0, cycles = 0, seed = 90712, n, k;
    int m_run = 0, m_ov = 1, m_cf = 0, m_df = 0, m_cur = 0, m_oc = 1, m_od = 1;

    ppms_partner u_partner (.supply_mv_i(sup), .top_cell_mv_i(top), .cell_max_mv_i(cmax),
        .por_o(por), .cutoff_o(cut), .entry_o(ent), .top_o(attop),
        .cell_high_o(chigh), .below_rel_o(brel));
    ppms_sequencer #(.HOLDOFF(HOLD), .OV_REC(OVR), .OC_REC(20), .FLT_DLY(4),
        .TEST_DLY(TD), .TEST_OC_REC(TOC), .TEST_DWELL(DW), .CTR_SAMPLE(1)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_above_por_i(por),
        .supply_above_cutoff_i(cut), .supply_above_test_entry_i(ent),
        .supply_at_top_cell_i(attop), .cell_high_raw_i(chigh),
        .cell_below_release_i(brel), .chg_fault_raw_i(chg_flt),
        .dsg_fault_raw_i(dsg_flt), .current_fault_raw_i(cur_flt),
        .charge_override_input_i(ovr_c), .discharge_override_input_i(ovr_d),
        .charge_fet_drive_o(charge_fet_drive), .discharge_fet_drive_o(discharge_fet_drive),
        .state_comparator_en_o(cmp), .fault_detect_en_o(fden),
        .fast_test_mode_o(fast_test_mode), .fault_mode_o(fmode));

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Cycle count inside a window
    task chk_in(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: pick = charge_fet_drive;
            1: pick = discharge_fet_drive;
            default: pick = fast_test_mode;
        endcase
    endfunction
    task wait_lvl(input int w, input logic v, input int lim);
        n = 0;
        while (pick(w) !== v && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    // Reference model of both drivers and the comparator enable
    task check_all();
        int ec;
        int ed;
        ec = m_run & m_oc & !m_ov & !m_cf & !m_cur;
        ed = m_run & m_od & !m_df & !m_cur;
        chk(charge_fet_drive, ec[0]);
        chk(discharge_fet_drive, ed[0]);
        chk(cmp, ec[0] ^ ed[0]);
    endtask

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        check_all();
        repeat (30) @(negedge clk_i);
        check_all();
        sup = 16'h3E80;
        cmax = 16'h10CC;
        wait_lvl(1, 1'b1, 400);
        chk_in(n, 70, 300);
        m_run = 1;
        repeat (50) @(negedge clk_i);
        check_all();
        cmax = 16'h0E74;
        wait_lvl(0, 1'b1, 200);
        chk_in(n, OVR, 199);
        m_ov = 0;
        check_all();
        for (k = 0; k < 3; k++) begin
            {cur_flt, dsg_flt, chg_flt} = 3'b001 << k;
            m_cf = int'(chg_flt);
            m_df = int'(dsg_flt);
            m_cur = int'(cur_flt);
            repeat (20) @(negedge clk_i);
            check_all();
            chk(fmode, 1'b1);
            {cur_flt, dsg_flt, chg_flt} = 3'b000;
            m_cf = 0;
            m_df = 0;
            m_cur = 0;
            wait_lvl(0, 1'b1, 300);
            wait_lvl(1, 1'b1, 300);
            check_all();
            chk(fmode, 1'b0);
        end
        // Random short drops must not pass the filter
        repeat (40) begin
            ovr_c = ($random(seed) % 4) != 0;
            @(negedge clk_i);
        end
        ovr_c = 1'b1;
        chk(charge_fet_drive, 1'b1);
        // Refill the counter so the release time starts from full range
        repeat (100) @(negedge clk_i);
        ovr_c = 1'b0;
        wait_lvl(0, 1'b0, 200);
        chk_in(n, 60, 199);
        m_oc = 0;
        check_all();
        ovr_c = 1'b1;
        wait_lvl(0, 1'b1, 200);
        m_oc = 1;
        sup = 16'h0BB8;
        repeat (3) @(negedge clk_i);
        m_run = 0;
        check_all();
        chk(fden, 1'b0);
        sup = 16'h1388;
        repeat (100) @(negedge clk_i);
        check_all();
        sup = 16'h3E80;
        wait_lvl(1, 1'b1, 400);
        wait_lvl(0, 1'b1, 400);
        m_run = 1;
        check_all();
        chk(fden, 1'b1);
        sup = 16'h4650;
        repeat (DW - 4) @(negedge clk_i);
        sup = 16'h4268;
        repeat (5) @(negedge clk_i);
        chk(fast_test_mode, 1'b0);
        sup = 16'h4650;
        wait_lvl(2, 1'b1, 40);
        chk_in(n, DW - 1, 39);
        // Off the top-cell band so the exit dwell does not start
        sup = 16'h4268;
        // Qualify timers take the test value one cycle after entry
        @(negedge clk_i);
        chg_flt = 1'b1;
        wait_lvl(0, 1'b0, 10);
        chk_in(n, 0, TD + 2);
        chg_flt = 1'b0;
        wait_lvl(0, 1'b1, 20);
        chk_in(n, 0, TD + 6);
        cur_flt = 1'b1;
        wait_lvl(1, 1'b0, 10);
        chk_in(n, 0, TD + 2);
        cur_flt = 1'b0;
        wait_lvl(1, 1'b1, 30);
        chk_in(n, 0, TOC + 6);
        sup = 16'h3E80;
        wait_lvl(2, 1'b0, 40);
        chk_in(n, DW - 1, 39);
        repeat (5) @(negedge clk_i);
        check_all();
        // Cell-high fault while running, then timed recovery
        cmax = 16'h10CC;
        m_ov = 1;
        repeat (20) @(negedge clk_i);
        check_all();
        chk(fmode, 1'b1);
        cmax = 16'h0E74;
        wait_lvl(0, 1'b1, 200);
        chk_in(n, OVR, 199);
        m_ov = 0;
        check_all();
        end_of_test();
    end
endmodule
`default_nettype wire
